//--- hdl/vseq_params.svh
/*
 * Constants of the vertical pattern sequencer: widths, group codes and limits.
 * Assumes it is included by the package, by the sequencer and by the bench.
 */
// What this block does
// - repeat group A per first-line to fourth-line 13-bit repetition counts.
// - groups B, C, D use odd or even 13-bit counts by line parity.
// - four hold positions freeze the vertical outputs while masking is enabled and map enable is low.
// - four continue positions let frozen outputs resume normal pattern operation.
// - in alternation, hold positions give the low 13 bits of select words.
// - in alternation, continue positions give the upper five select bits.
// - final repetition uses a separate length when its enable is set.
// - optional fifth toggle position per group, active only when enabled.
// - the fifth toggle acts on all vertical outputs of the group together.
// - alternation mode runs while its one-bit enable is high.
// - map enable turns hold/continue storage into select words; software sets it.
// - select words are 18 bits, one segment per bit, 18 segments maximum.
// - even and odd lines use their own select word pairs.
// - insert enable bits 0..2 insert groups B, C, D into one A repetition.
// - select bits pair as {word1, word0}: 00 A, 01 B, 10 C, 11 D.
// - in alternation, group A first-line count gives segments per line, max 18.
`ifndef VSEQ_PARAMS_SVH
`define VSEQ_PARAMS_SVH

`define VS_POS_W    13
`define VS_SEL_W    18
`define VS_SEL_HI_W 5
`define VS_SEG_W    5
`define VS_VOUT_W   24
`define VS_MAX_SEG  18
`define VS_SPC_W    3
`define VS_GRP_A    2'h0
`define VS_LINE_PRE 2'h3

`endif

//--- hdl/vseq_pkg.sv
/*
 * Types of the vertical pattern sequencer: configuration image and state record.
 * Assumes the constants header is on the include path.
 */
`include "vseq_params.svh"

package vseq_pkg;

    typedef logic [`VS_POS_W-1:0] pos_t;

    typedef enum logic [2:0] {
        ST_IDLE   = 3'b000,
        ST_WAIT   = 3'b001,
        ST_RUN    = 3'b010,
        ST_INSERT = 3'b011,
        ST_ALT    = 3'b100,
        ST_DONE   = 3'b101
    } seq_state_t;

    typedef struct packed {
        logic [3:0][`VS_POS_W-1:0] rep_a;        // group_a_rep first..fourth line
        logic [3:1][`VS_POS_W-1:0] rep_odd;      // group_b/c/d_rep_odd_line
        logic [3:1][`VS_POS_W-1:0] rep_even;     // group_b/c/d_rep_even_line
        logic [3:0][`VS_POS_W-1:0] hold_pos;     // hold_position_one..four
        logic [3:0][`VS_POS_W-1:0] cont_pos;     // continue_position_one..four
        logic [3:0][`VS_POS_W-1:0] pat_len;      // group pattern lengths
        logic [3:0][`VS_POS_W-1:0] final_len;    // final_rep_length_a..d
        logic [3:0][`VS_POS_W-1:0] tog1;         // first toggle of each group
        logic [3:0][`VS_POS_W-1:0] tog2;         // second toggle of each group
        logic [3:0][`VS_POS_W-1:0] fifth_tog;    // fifth_toggle_a..d
        logic [3:0]                final_len_en; // final_rep_length_enable
        logic [3:0]                fifth_en;     // fifth_toggle_enable
        logic                      alt_en;       // seq_alternation_enable
        logic                      map_en;       // select_map_enable
        logic                      mask_en;      // vertical_masking_enable
        logic [`VS_SPC_W-1:0]      spc_en;       // special_insert_enable
        logic [`VS_VOUT_W-1:0]     vpol;         // start polarity per output
    } cfg_t;

    typedef struct packed {
        cfg_t                  cfg;
        seq_state_t            state;
        logic [1:0]            grp;
        pos_t                  rep_cnt;
        pos_t                  pos;
        pos_t                  pixel;
        logic [`VS_SEG_W-1:0]  seg;
        logic [1:0]            line;
        logic                  parity;
        logic                  frozen;
        logic                  busy;
        logic [`VS_VOUT_W-1:0] vout;
    } state_t;

endpackage

//--- hdl/vseq_ctrl.sv
/*
 * Vertical pattern sequencer: plays groups A..D with repetition, insertion,
 * alternation of segments, final-repetition length and output freezing.
 * Assumes line_start and seq_enable are synchronous to mclk and that the
 * configuration image is stable while cfg_load is high.
 */
`include "vseq_params.svh"
`timescale 1ns/1ps
`default_nettype none

module vertical_pattern_sequence_ctrl #(
    parameter int MAX_SEGMENTS = `VS_MAX_SEG
) (
    input  wire logic                  mclk,
    input  wire logic                  rst_n,
    input  wire logic                  clk_en,
    input  wire logic                  seq_enable,
    input  wire logic                  line_start,
    input  wire logic                  cfg_load,
    input  wire vseq_pkg::cfg_t        cfg_in,
    output logic [`VS_VOUT_W-1:0]      vertical_out,
    output logic                       seq_busy,
    output logic                       line_parity,
    output logic                       hold_active
);

    // ------------------------------------------------------------
    // elaboration checks
    // ------------------------------------------------------------
    if (MAX_SEGMENTS < 1 || MAX_SEGMENTS > `VS_MAX_SEG) begin : g_bad_seg
        $error("MAX_SEGMENTS must lie between 1 and the select word width");
    end

    // ------------------------------------------------------------
    // helper functions
    // ------------------------------------------------------------
    function automatic vseq_pkg::pos_t rep_of(input vseq_pkg::cfg_t c, input logic [1:0] g,
                                              input logic par, input logic [1:0] ln);
        if (g == `VS_GRP_A)
            return c.rep_a[ln];
        else if (par)
            return c.rep_odd[g];
        else
            return c.rep_even[g];
    endfunction

    // next group after g with a nonzero count; bit 2 marks a hit
    function automatic logic [2:0] next_grp(input vseq_pkg::cfg_t c, input logic [1:0] g,
                                            input logic par, input logic [1:0] ln);
        logic [2:0] r;
        r = 3'h0;
        for (int k = 3; k >= 1; k--) begin
            if (2'(k) > g && rep_of(c, 2'(k), par, ln) != '0)
                r = {1'b1, 2'(k)};
        end
        return r;
    endfunction

    // next enabled insertion group after g
    function automatic logic [2:0] next_ins(input vseq_pkg::cfg_t c, input logic [1:0] g);
        logic [2:0] r;
        r = 3'h0;
        for (int k = 3; k >= 1; k--) begin
            if (2'(k) > g && c.spc_en[k-1])
                r = {1'b1, 2'(k)};
        end
        return r;
    endfunction

    // select word i: 0 word0 even, 1 word1 even, 2 word0 odd, 3 word1 odd
    function automatic logic [`VS_SEL_W-1:0] sel_word(input vseq_pkg::cfg_t c, input logic [1:0] i);
        if (c.map_en)
            return {c.cont_pos[i][`VS_SEL_HI_W-1:0], c.hold_pos[i]};
        else
            return '0;
    endfunction

    function automatic logic [1:0] sel_code(input vseq_pkg::cfg_t c, input logic par,
                                            input logic [`VS_SEG_W-1:0] s);
        logic [`VS_SEL_W-1:0] w0;
        logic [`VS_SEL_W-1:0] w1;
        w0 = sel_word(c, {par, 1'b0});
        w1 = sel_word(c, {par, 1'b1});
        return {w1[s], w0[s]};
    endfunction

    // all outputs of one group share these toggles, so the group moves as one
    function automatic logic pat_level(input vseq_pkg::cfg_t c, input logic [1:0] g,
                                       input vseq_pkg::pos_t p);
        return (p >= c.tog1[g]) ^ (p >= c.tog2[g])
             ^ (c.fifth_en[g] && p >= c.fifth_tog[g]);
    endfunction

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    vseq_pkg::state_t       st_reg;
    vseq_pkg::state_t       st_next;
    logic                   hold_hit;
    logic                   cont_hit;
    vseq_pkg::pos_t         rep_tgt;
    vseq_pkg::pos_t         rep_tgt_a;
    logic                   last_rep;
    vseq_pkg::pos_t         cur_len;
    logic                   rep_end;
    logic [`VS_SEG_W-1:0]   alt_cnt;
    logic [1:0]             ln;
    logic                   par;
    logic [2:0]             nx;
    logic                   lvl;
    logic                   playing;

    always_comb begin
        st_next   = st_reg;
        hold_hit  = 1'b0;
        cont_hit  = 1'b0;
        nx        = 3'h0;
        ln        = st_reg.line + 2'h1;
        par       = ~st_reg.parity;
        for (int i = 0; i < 4; i++) begin
            if (st_reg.cfg.hold_pos[i] == st_reg.pixel)
                hold_hit = st_reg.cfg.mask_en && !st_reg.cfg.map_en;
            if (st_reg.cfg.cont_pos[i] == st_reg.pixel)
                cont_hit = st_reg.cfg.mask_en && !st_reg.cfg.map_en;
        end
        rep_tgt   = rep_of(st_reg.cfg, st_reg.grp, st_reg.parity, st_reg.line);
        rep_tgt_a = rep_of(st_reg.cfg, `VS_GRP_A, st_reg.parity, st_reg.line);
        last_rep  = (st_reg.state == vseq_pkg::ST_RUN) && (st_reg.rep_cnt == rep_tgt - 13'h1);
        cur_len   = (last_rep && st_reg.cfg.final_len_en[st_reg.grp]) ? st_reg.cfg.final_len[st_reg.grp]
                                                                      : st_reg.cfg.pat_len[st_reg.grp];
        rep_end   = ({1'b0, st_reg.pos} + 14'h1) >= {1'b0, cur_len};
        alt_cnt   = (st_reg.cfg.rep_a[0] > 13'(MAX_SEGMENTS)) ? 5'(MAX_SEGMENTS)
                                                              : st_reg.cfg.rep_a[0][`VS_SEG_W-1:0];
        playing   = (st_reg.state == vseq_pkg::ST_RUN) || (st_reg.state == vseq_pkg::ST_INSERT)
                 || (st_reg.state == vseq_pkg::ST_ALT);
        lvl       = playing && pat_level(st_reg.cfg, st_reg.grp, st_reg.pos);

        // loading at once keeps the port simple; load between lines to avoid a torn line
        if (cfg_load)
            st_next.cfg = cfg_in;
        st_next.pixel  = st_reg.pixel + 13'h1;
        st_next.frozen = (st_reg.frozen | hold_hit) & ~cont_hit;
        // the hold stage looks at the registered flag, so the output takes one more update from the hit cycle and stops after it
        st_next.vout   = st_reg.frozen ? st_reg.vout : ({`VS_VOUT_W{lvl}} ^ st_reg.cfg.vpol);

        if (!seq_enable) begin
            st_next.state  = vseq_pkg::ST_IDLE;
            st_next.frozen = 1'b0;
        end else if (st_reg.state == vseq_pkg::ST_IDLE) begin
            st_next.state  = vseq_pkg::ST_WAIT;
            st_next.line   = `VS_LINE_PRE;
            st_next.parity = 1'b1;
        end else if (line_start) begin
            st_next.line    = ln;
            st_next.parity  = par;
            st_next.pixel   = '0;
            st_next.frozen  = 1'b0;
            st_next.pos     = '0;
            st_next.rep_cnt = '0;
            st_next.seg     = '0;
            if (st_reg.cfg.alt_en) begin
                if (alt_cnt != '0) begin
                    st_next.state = vseq_pkg::ST_ALT;
                    st_next.grp   = sel_code(st_reg.cfg, par, '0);
                end else begin
                    st_next.state = vseq_pkg::ST_DONE;
                end
            end else if (rep_of(st_reg.cfg, `VS_GRP_A, par, ln) != '0) begin
                st_next.state = vseq_pkg::ST_RUN;
                st_next.grp   = `VS_GRP_A;
            end else begin
                nx            = next_grp(st_reg.cfg, `VS_GRP_A, par, ln);
                st_next.state = nx[2] ? vseq_pkg::ST_RUN : vseq_pkg::ST_DONE;
                st_next.grp   = nx[1:0];
            end
        end else begin
            case (st_reg.state)
                vseq_pkg::ST_RUN: begin
                    st_next.pos = st_reg.pos + 13'h1;
                    if (rep_end) begin
                        st_next.pos     = '0;
                        st_next.rep_cnt = st_reg.rep_cnt + 13'h1;
                        nx = next_ins(st_reg.cfg, `VS_GRP_A);
                        if (st_reg.grp == `VS_GRP_A && st_reg.rep_cnt == '0 && nx[2]) begin
                            st_next.state = vseq_pkg::ST_INSERT;
                            st_next.grp   = nx[1:0];
                        end else if (st_reg.rep_cnt + 13'h1 >= rep_tgt) begin
                            nx              = next_grp(st_reg.cfg, st_reg.grp, st_reg.parity, st_reg.line);
                            st_next.rep_cnt = '0;
                            st_next.state   = nx[2] ? vseq_pkg::ST_RUN : vseq_pkg::ST_DONE;
                            st_next.grp     = nx[1:0];
                        end
                    end
                end
                vseq_pkg::ST_INSERT: begin
                    st_next.pos = st_reg.pos + 13'h1;
                    if (rep_end) begin
                        st_next.pos = '0;
                        nx = next_ins(st_reg.cfg, st_reg.grp);
                        if (nx[2]) begin
                            st_next.grp = nx[1:0];
                        end else if (rep_tgt_a > 13'h1) begin
                            st_next.state = vseq_pkg::ST_RUN;
                            st_next.grp   = `VS_GRP_A;
                        end else begin
                            nx              = next_grp(st_reg.cfg, `VS_GRP_A, st_reg.parity, st_reg.line);
                            st_next.rep_cnt = '0;
                            st_next.state   = nx[2] ? vseq_pkg::ST_RUN : vseq_pkg::ST_DONE;
                            st_next.grp     = nx[1:0];
                        end
                    end
                end
                vseq_pkg::ST_ALT: begin
                    st_next.pos = st_reg.pos + 13'h1;
                    if (rep_end) begin
                        st_next.pos = '0;
                        if (st_reg.seg + 5'h1 < alt_cnt) begin
                            st_next.seg = st_reg.seg + 5'h1;
                            st_next.grp = sel_code(st_reg.cfg, st_reg.parity, st_reg.seg + 5'h1);
                        end else begin
                            st_next.state = vseq_pkg::ST_DONE;
                        end
                    end
                end
                default: begin
                    st_next.pos = st_reg.pos;
                end
            endcase
        end
        st_next.busy = (st_next.state == vseq_pkg::ST_RUN) || (st_next.state == vseq_pkg::ST_INSERT)
                    || (st_next.state == vseq_pkg::ST_ALT);
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n)
            st_reg <= '0;
        else if (clk_en)
            st_reg <= st_next;
    end

    assign vertical_out = st_reg.vout;
    assign seq_busy     = st_reg.busy;
    assign line_parity  = st_reg.parity;
    assign hold_active  = st_reg.frozen;

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    sequence s_line_begin;
        clk_en && seq_enable && line_start && st_reg.state != vseq_pkg::ST_IDLE;
    endsequence

    sequence s_alt_line;
        s_line_begin ##0 st_reg.cfg.alt_en && alt_cnt != '0;
    endsequence

    a_parity_flip: assert property (s_line_begin |=> line_parity != $past(line_parity))
        else $error("line parity did not toggle at line start");
    a_alt_enter: assert property (s_alt_line |=> st_reg.state == vseq_pkg::ST_ALT && st_reg.seg == '0)
        else $error("alternation mode not entered at line start");
    a_freeze_hold: assert property (hold_active && clk_en |=> $stable(vertical_out))
        else $error("vertical outputs changed while held");
    a_hold_set: assert property (clk_en && seq_enable && !line_start && hold_hit && !cont_hit
                                 |=> hold_active)
        else $error("hold position did not freeze outputs");
    a_resume_clear: assert property (clk_en && cont_hit |=> !hold_active)
        else $error("continue position did not release outputs");
    a_alt_code: assert property (st_reg.state == vseq_pkg::ST_ALT
                                 |-> st_reg.grp == sel_code(st_reg.cfg, line_parity, st_reg.seg))
        else $error("segment group does not match select bits");
    a_alt_seg_bound: assert property (st_reg.state == vseq_pkg::ST_ALT
                                      |-> st_reg.seg < alt_cnt && alt_cnt <= 5'(`VS_MAX_SEG))
        else $error("segment index beyond programmed count");
    a_rep_bound: assert property (st_reg.state == vseq_pkg::ST_RUN |-> st_reg.rep_cnt < rep_tgt)
        else $error("repetition count beyond its target");
    a_final_len: assert property (clk_en && seq_enable && !line_start && last_rep
                                  && st_reg.cfg.final_len_en[st_reg.grp]
                                  && {1'b0, st_reg.pos} + 14'h1 == {1'b0, st_reg.cfg.final_len[st_reg.grp]}
                                  |=> st_reg.pos == '0)
        else $error("final repetition did not end at its own length");
    a_group_common: assert property (playing && !hold_active && clk_en
                                     |=> (vertical_out ^ st_reg.cfg.vpol) == '0
                                      || (vertical_out ^ st_reg.cfg.vpol) == '1)
        else $error("outputs of one group did not toggle together");
    a_enable_freeze: assert property (!clk_en |=> $stable(st_reg))
        else $error("state changed while clock enable was low");

endmodule

`default_nettype wire

//--- verification/ccd_vclock_model.sv
/*
 * Far-side model of the sensor's vertical clock drivers: watches the 24 vertical lines.
 * Assumes mclk is the pixel clock and clr is a one-cycle pulse from the bench.
 */
`timescale 1ns/1ps
`default_nettype none

module ccd_vclock_model (
    input  wire logic        mclk,
    input  wire logic        rst_n,
    input  wire logic        clr,
    input  wire logic [23:0] vclk,
    input  wire logic        hold,
    output var int           high_cnt,
    output var int           mixed_cnt,
    output var int           frozen_err
);
    logic [23:0] last;
    logic        hold_d;

    // a driver bank only accepts all lines moving together
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            high_cnt = 0;
            mixed_cnt = 0;
            frozen_err = 0;
            hold_d = 1'b0;
            last = '0;
        end else begin
            if (clr) begin
                high_cnt = 0;
                mixed_cnt = 0;
                frozen_err = 0;
            end
            if (vclk === '1)
                high_cnt++;
            else if (vclk !== '0)
                mixed_cnt++;
            // first held cycle may still carry the last update
            if (hold === 1'b1 && hold_d && vclk !== last)
                frozen_err++;
            hold_d = (hold === 1'b1);
            last = vclk;
        end
    end
endmodule

`default_nettype wire

//--- verification/tb_vertical_pattern_sequence_ctrl.sv
/*
 * Self-checking bench: loads a configuration image, plays lines, measures busy length,
 * parity, hold time and pattern highs against values reckoned from the settings.
 * Assumes the design package and the constants header are compiled first.
 */
`include "vseq_params.svh"
`timescale 1ns/1ps
`default_nettype none

module tb_vertical_pattern_sequence_ctrl;
    logic                  mclk, rst_n, clk_en, seq_enable, line_start, cfg_load, clr;
    vseq_pkg::cfg_t        cfg_in, cfg;
    logic [`VS_VOUT_W-1:0] vertical_out;
    logic                  seq_busy, line_parity, hold_active;
    int                    high_cnt, mixed_cnt, frozen_err, n_fail, n_compared, cyc, ln;

    vertical_pattern_sequence_ctrl #(.MAX_SEGMENTS(18)) i_vertical_pattern_sequence_ctrl (
        .mclk(mclk), .rst_n(rst_n), .clk_en(clk_en), .seq_enable(seq_enable), .line_start(line_start),
        .cfg_load(cfg_load), .cfg_in(cfg_in), .vertical_out(vertical_out), .seq_busy(seq_busy),
        .line_parity(line_parity), .hold_active(hold_active));

    ccd_vclock_model i_ccd_vclock_model (
        .mclk(mclk), .rst_n(rst_n), .clr(clr), .vclk(vertical_out), .hold(hold_active),
        .high_cnt(high_cnt), .mixed_cnt(mixed_cnt), .frozen_err(frozen_err));

    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end

    // ----------------------------------------
    // expected line length from the settings
    // ----------------------------------------
    function automatic int glen(vseq_pkg::cfg_t c, int g, bit fin);
        int l;
        l = (fin && c.final_len_en[g]) ? int'(c.final_len[g]) : int'(c.pat_len[g]);
        return (l == 0) ? 1 : l;
    endfunction

    function automatic int exp_busy(vseq_pkg::cfg_t c, int l, bit par);
        int t, r, n;
        logic [17:0] w0, w1;
        t = 0;
        if (c.alt_en) begin
            w0 = par ? {c.cont_pos[2][4:0], c.hold_pos[2]} : {c.cont_pos[0][4:0], c.hold_pos[0]};
            w1 = par ? {c.cont_pos[3][4:0], c.hold_pos[3]} : {c.cont_pos[1][4:0], c.hold_pos[1]};
            if (!c.map_en) begin
                w0 = '0;
                w1 = '0;
            end
            n = (c.rep_a[0] > 18) ? 18 : int'(c.rep_a[0]);
            for (int s = 0; s < n; s++) t += glen(c, {w1[s], w0[s]}, 1'b0);
            return t;
        end
        for (int g = 0; g < 4; g++) begin
            r = (g == 0) ? int'(c.rep_a[l % 4]) : int'(par ? c.rep_odd[g] : c.rep_even[g]);
            if (r > 0) t += (r - 1) * glen(c, g, 1'b0) + glen(c, g, 1'b1);
            if (g == 0 && r > 0)
                for (int b = 0; b < 3; b++) if (c.spc_en[b]) t += glen(c, b + 1, 1'b0);
        end
        return t;
    endfunction

    // ----------------------------------------
    // access tasks
    // ----------------------------------------
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("Error t=%0t got=%0h exp=%0h", $time, got, exp);
        end
    endtask

    task automatic start();
        @(negedge mclk) seq_enable = 1'b0;
        cfg_load = 1'b1;
        cfg_in = cfg;
        @(negedge mclk) cfg_load = 1'b0;
        seq_enable = 1'b1;
        repeat (2) @(negedge mclk);
        // a line start while the clock enable is low must be ignored
        clk_en = 1'b0;
        line_start = 1'b1;
        repeat (2) @(negedge mclk);
        clk_en = 1'b1;
        line_start = 1'b0;
        check({31'h0, line_parity}, 32'h1);
        ln = 0;
    endtask

    // exp_high below zero skips the pattern-high comparison
    task automatic run_line(input int exp_high, input int exp_hold);
        int   nb, nh, to;
        bit   par;
        logic par_seen;
        par = ln[0];
        nb = 0;
        nh = 0;
        to = 0;
        par_seen = 1'bx;
        @(negedge mclk) line_start = 1'b1;
        clr = 1'b1;
        @(negedge mclk) line_start = 1'b0;
        clr = 1'b0;
        while (to < 600 && !(nb > 0 && seq_busy !== 1'b1)) begin
            if (seq_busy === 1'b1) begin
                if (nb == 0) par_seen = line_parity;
                nb++;
            end
            if (hold_active === 1'b1) nh++;
            to++;
            @(negedge mclk);
        end
        repeat (3) @(negedge mclk);
        check(nb, exp_busy(cfg, ln, par));
        check({31'h0, par_seen}, {31'h0, par});
        if (exp_high >= 0) check(high_cnt, exp_high);
        check(nh, exp_hold);
        check(mixed_cnt, 0);
        check(frozen_err, 0);
        ln++;
    endtask

    task automatic final_report();
        $display("compared %0d mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // hang guard, well above the fewer than one thousand cycles the tests take
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            final_report();
        end
    end

    // ----------------------------------------
    // test sequence
    // ----------------------------------------
    initial begin
        n_fail = 0;
        n_compared = 0;
        cyc = 0;
        ln = 0;
        rst_n = 1'b0;
        clk_en = 1'b1;
        seq_enable = 1'b0;
        line_start = 1'b0;
        cfg_load = 1'b0;
        clr = 1'b0;
        cfg = '0;
        cfg_in = '0;
        repeat (3) @(posedge mclk);
        @(negedge mclk) rst_n = 1'b1;
        cfg.pat_len = {13'h0005, 13'h0004, 13'h0002, 13'h0003};
        cfg.final_len = cfg.pat_len;
        cfg.rep_a = {13'h0004, 13'h0003, 13'h0001, 13'h0002};
        cfg.rep_even = {13'h0000, 13'h0002, 13'h0001};
        cfg.rep_odd = {13'h0001, 13'h0000, 13'h0003};
        start();
        repeat (5) run_line(0, 0);
        $display("test repetition counts done");
        cfg.final_len_en = 4'hF;
        cfg.final_len[0] = 13'h0007;
        cfg.final_len[1] = 13'h0001;
        start();
        repeat (2) run_line(0, 0);
        cfg.final_len_en = 4'h0;
        cfg.final_len = cfg.pat_len;
        $display("test final length done");
        for (int b = 1; b < 8; b++) begin
            cfg.spc_en = b[2:0];
            start();
            run_line(0, 0);
        end
        $display("test insertion done");
        cfg.spc_en = 3'h0;
        cfg.alt_en = 1'b1;
        cfg.map_en = 1'b1;
        cfg.rep_a[0] = 13'h0014;
        cfg.hold_pos = {13'h1C71, 13'h0333, 13'h0F0F, 13'h1555};
        cfg.cont_pos = {13'h0013, 13'h000C, 13'h0005, 13'h001A};
        start();
        repeat (2) run_line(0, 0);
        cfg.rep_a[0] = 13'h0005;
        start();
        repeat (2) run_line(0, 0);
        cfg.alt_en = 1'b0;
        start();
        run_line(0, 0);
        $display("test alternation done");
        cfg.map_en = 1'b0;
        cfg.rep_a = {4{13'h0002}};
        cfg.rep_even = '0;
        cfg.rep_odd = '0;
        cfg.pat_len[0] = 13'h0004;
        cfg.final_len[0] = 13'h0004;
        cfg.tog1[0] = 13'h0001;
        cfg.tog2[0] = 13'h0002;
        start();
        run_line(2, 0);
        cfg.fifth_en[0] = 1'b1;
        cfg.fifth_tog[0] = 13'h0003;
        start();
        run_line(4, 0);
        $display("test fifth toggle done");
        cfg.fifth_en = 4'h0;
        cfg.rep_a = {4{13'h0001}};
        cfg.pat_len[0] = 13'h0014;
        cfg.final_len[0] = 13'h0014;
        cfg.tog2[0] = 13'h0006;
        cfg.mask_en = 1'b1;
        cfg.hold_pos = {4{13'h0004}};
        cfg.cont_pos = {4{13'h0009}};
        start();
        run_line(9, 5);
        cfg.map_en = 1'b1;
        start();
        run_line(5, 0);
        $display("test hold done");
        final_report();
    end
endmodule

`default_nettype wire
